// ---- rtl/slsc_consts.svh ----
// offsets, field positions, reset values and factor codes of the sync control bank
`ifndef SLSC_CONSTS_SVH
`define SLSC_CONSTS_SVH

// register indexes; byte address is four times the index
`define SLSC_IDX_FORTY 8'h16
`define SLSC_IDX_SYNC_SEL 8'h36
`define SLSC_IDX_PLL 8'h37
`define SLSC_IDX_SE_EN 8'h3c
`define SLSC_IDX_SYSREF_MASK 8'h3e
`define SLSC_IDX_PAGE_CTRL 8'h40
`define SLSC_IDX_STATUS 8'h41

// field positions
`define SLSC_BIT_SE_SELECT 6
`define SLSC_BIT_SE_ENABLE 0
`define SLSC_BIT_PAGE_CTRL 0
`define SLSC_BIT_DIV_MASK 6
`define SLSC_BIT_OSC_MASK 5
`define SLSC_POS_PLL_LO 0
`define SLSC_POS_FORTY_LO 4

// reset values
`define SLSC_RST_BIT 1'b0
`define SLSC_RST_PLL 2'h0
`define SLSC_RST_FORTY 3'h0

// pll factor codes and the multipliers they select
`define SLSC_PLL_20X 2'h0
`define SLSC_PLL_16X 2'h1
`define SLSC_PLL_40X 2'h2
`define SLSC_PLL_80X 2'h3
`define SLSC_MULT_20X 7'h14
`define SLSC_MULT_16X 7'h10
`define SLSC_MULT_40X 7'h28
`define SLSC_MULT_80X 7'h50

// forty-times configuration values
`define SLSC_FORTY_ON 3'h7
`define SLSC_FORTY_OFF 3'h0

`endif

// ---- rtl/slsc_pkg.sv ----
// types shared by the sync control bank
package slsc_pkg;

   // pins from the link side, all asynchronous
   typedef struct packed {
      logic syncb_diff;
      logic aux_pin_four;
      logic sysref;
   } slsc_pins_t;

   // one-cycle sysref reset pulses toward the datapath
   typedef struct packed {
      logic clkdiv_rst;
      logic nco_rst;
      logic lmfc_rst;
   } slsc_sync_out_t;

   // bus handshake states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACK = 2'b10
   } slsc_bus_state_t;

endpackage

// ---- rtl/slsc_sync2.sv ----
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
module slsc_sync2
#(
   parameter int W = 1
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule // slsc_sync2

// ---- rtl/slsc_regs.sv ----
// serial-link sync control register bank with avalon-mm slave
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/10ps
`include "slsc_consts.svh"
module slsc_regs
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [9:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire slsc_pkg::slsc_pins_t link_pins,
   output logic syncb_to_link,
   output logic [1:0] pll_factor,
   output logic [6:0] pll_mult,
   output slsc_pkg::slsc_sync_out_t sysref_resets
);
   import slsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   slsc_bus_state_t state_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [7:0] rd_d;
   logic [7:0] idx;
   logic wr_fire;
   logic se_select_q;
   logic se_enable_q;
   logic page_ctrl_q;
   logic [1:0] pll_factor_q;
   logic [2:0] forty_cfg_q;
   logic div_mask_q;
   logic osc_mask_q;
   slsc_pins_t pins_s;
   logic se_active;
   logic syncb_q;
   logic [1:0] settle_q;
   logic sysref_dly_q;
   logic sysref_rise;
   logic clkdiv_rst_q;
   logic nco_rst_q;
   logic lmfc_rst_q;
   logic [6:0] pll_mult_q;
   logic cfg_bad;

   assign idx = avs_address[9:2];

   ////////////////////////////////////////////////////////////////////////////
   // bus handshake: every access sees exactly one wait cycle

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ST_IDLE;
         wait_q <= 1'b1;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               if (avs_read || avs_write)
               begin
                  state_q <= ST_ACK;
                  wait_q <= 1'b0;
               end
            end
            ST_ACK:
            begin
               state_q <= ST_IDLE;
               wait_q <= 1'b1;
            end
            default:
            begin
               state_q <= ST_IDLE;
               wait_q <= 1'b1;
            end
         endcase
      end
   end

   // writes land only at the edge where waitrequest is seen low
   assign wr_fire = avs_write && (state_q == ST_ACK) && avs_byteenable[0];

   // read data captured a cycle early, held through the completing edge
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         rdata_q <= 32'h0000_0000;
      end
      else if (avs_read && state_q == ST_IDLE)
      begin
         rdata_q <= {24'h00_0000, rd_d};
      end
   end

   // read mux; reserved bits and unmapped indexes read zero
   always_comb
   begin
      rd_d = 8'h00;
      case (idx)
         `SLSC_IDX_FORTY: rd_d[`SLSC_POS_FORTY_LO +: 3] = forty_cfg_q;
         `SLSC_IDX_SYNC_SEL: rd_d[`SLSC_BIT_SE_SELECT] = se_select_q;
         `SLSC_IDX_PLL: rd_d[`SLSC_POS_PLL_LO +: 2] = pll_factor_q;
         `SLSC_IDX_SE_EN: rd_d[`SLSC_BIT_SE_ENABLE] = se_enable_q;
         `SLSC_IDX_SYSREF_MASK:
         begin
            rd_d[`SLSC_BIT_DIV_MASK] = div_mask_q;
            rd_d[`SLSC_BIT_OSC_MASK] = osc_mask_q;
         end
         `SLSC_IDX_PAGE_CTRL: rd_d[`SLSC_BIT_PAGE_CTRL] = page_ctrl_q;
         `SLSC_IDX_STATUS: rd_d[3:0] = {cfg_bad, pins_s.sysref, syncb_q, se_active};
         default: rd_d = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers; reserved bits are dropped, not stored

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         se_select_q <= `SLSC_RST_BIT;
         se_enable_q <= `SLSC_RST_BIT;
         page_ctrl_q <= `SLSC_RST_BIT;
         pll_factor_q <= `SLSC_RST_PLL;
         forty_cfg_q <= `SLSC_RST_FORTY;
         div_mask_q <= `SLSC_RST_BIT;
         osc_mask_q <= `SLSC_RST_BIT;
      end
      else if (wr_fire)
      begin
         case (idx)
            `SLSC_IDX_FORTY: forty_cfg_q <= avs_writedata[`SLSC_POS_FORTY_LO +: 3];
            `SLSC_IDX_SYNC_SEL: se_select_q <= avs_writedata[`SLSC_BIT_SE_SELECT];
            `SLSC_IDX_PLL: pll_factor_q <= avs_writedata[`SLSC_POS_PLL_LO +: 2];
            `SLSC_IDX_SE_EN: se_enable_q <= avs_writedata[`SLSC_BIT_SE_ENABLE];
            `SLSC_IDX_SYSREF_MASK:
            begin
               div_mask_q <= avs_writedata[`SLSC_BIT_DIV_MASK];
               osc_mask_q <= avs_writedata[`SLSC_BIT_OSC_MASK];
            end
            `SLSC_IDX_PAGE_CTRL: page_ctrl_q <= avs_writedata[`SLSC_BIT_PAGE_CTRL];
            default: page_ctrl_q <= page_ctrl_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; sysref edges are only seen after two flops

   slsc_sync2 #(.W(3)) u_pin_sync
   (
      .clk(ref_clk),
      .rst(sys_rst),
      .d(link_pins),
      .q(pins_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // syncb source select

   // select alone does nothing until enable and page control are set
   assign se_active = se_select_q && se_enable_q && page_ctrl_q;

   // syncb holds its idle level until the synchronisers carry real pin samples;
   // their reset value of zero would otherwise read as a sync request
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         settle_q <= 2'b00;
      end
      else
      begin
         settle_q <= {settle_q[0], 1'b1};
      end
   end

   // differential input is not looked at while aux source is active
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         syncb_q <= 1'b1;
      end
      else if (settle_q[1])
      begin
         syncb_q <= se_active ? pins_s.aux_pin_four : pins_s.syncb_diff;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pll factor decode

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pll_mult_q <= `SLSC_MULT_20X;
      end
      else
      begin
         case (pll_factor_q)
            `SLSC_PLL_20X: pll_mult_q <= `SLSC_MULT_20X;
            `SLSC_PLL_16X: pll_mult_q <= `SLSC_MULT_16X;
            `SLSC_PLL_40X: pll_mult_q <= `SLSC_MULT_40X;
            `SLSC_PLL_80X: pll_mult_q <= `SLSC_MULT_80X;
            default: pll_mult_q <= `SLSC_MULT_20X;
         endcase
      end
   end

   // flags a forty-times field that does not suit the chosen factor
   always_comb
   begin
      case (pll_factor_q)
         `SLSC_PLL_40X: cfg_bad = (forty_cfg_q != `SLSC_FORTY_ON);
         `SLSC_PLL_16X: cfg_bad = 1'b0;
         default: cfg_bad = (forty_cfg_q != `SLSC_FORTY_OFF);
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sysref edge and masked reset pulses

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sysref_dly_q <= 1'b0;
      end
      else
      begin
         sysref_dly_q <= pins_s.sysref;
      end
   end

   // only a low-to-high move counts; a held level fires once
   assign sysref_rise = pins_s.sysref && !sysref_dly_q;

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clkdiv_rst_q <= 1'b0;
         nco_rst_q <= 1'b0;
         lmfc_rst_q <= 1'b0;
      end
      else
      begin
         clkdiv_rst_q <= sysref_rise && !div_mask_q;
         nco_rst_q <= sysref_rise && !osc_mask_q;
         lmfc_rst_q <= sysref_rise && !osc_mask_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   assign syncb_to_link = syncb_q;
   assign pll_factor = pll_factor_q;
   assign pll_mult = pll_mult_q;
   assign sysref_resets = '{clkdiv_rst: clkdiv_rst_q, nco_rst: nco_rst_q, lmfc_rst: lmfc_rst_q};

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   a_sync_diff_path: assert property ((settle_q[1] && !se_active)
      |=> syncb_q == $past(pins_s.syncb_diff))
      else $error("syncb not taken from differential input");
   a_sync_aux_path: assert property (se_active |=> syncb_q == $past(pins_s.aux_pin_four))
      else $error("syncb not taken from aux pin");
   a_diff_ignored: assert property ((se_active && $past(se_active)
      && $stable(pins_s.aux_pin_four)) |=> $stable(syncb_q))
      else $error("differential syncb leaked through");
   a_select_gated: assert property ((se_select_q && !(se_enable_q && page_ctrl_q))
      |=> syncb_q == $past(pins_s.syncb_diff))
      else $error("select acted without enable and page control");
   a_pll_forty_map: assert property ((pll_factor_q == `SLSC_PLL_40X)
      |=> pll_mult_q == `SLSC_MULT_40X)
      else $error("pll factor decode wrong");
   a_clkdiv_reset: assert property (($rose(pins_s.sysref) && !div_mask_q) |=> clkdiv_rst_q)
      else $error("divider reset missing on sysref rise");
   a_clkdiv_masked: assert property (div_mask_q |=> !clkdiv_rst_q)
      else $error("masked divider was reset");
   a_osc_reset: assert property (($rose(pins_s.sysref) && !osc_mask_q)
      |=> nco_rst_q && lmfc_rst_q)
      else $error("nco or lmfc reset missing on sysref rise");
   a_osc_masked: assert property (osc_mask_q |=> !nco_rst_q && !lmfc_rst_q)
      else $error("masked nco or lmfc was reset");
   a_bus_one_wait: assert property ((state_q == ST_IDLE && (avs_read || avs_write))
      |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus wait sequence wrong");

endmodule // slsc_regs

// ---- test/slsc_link_model.sv ----
// far-side model: syncb receiver levels and a sysref source
`timescale 1ns/10ps
module slsc_link_model
(
   input wire logic ref_clk,
   input wire logic diff_lvl,
   input wire logic aux_lvl,
   input wire logic fire,
   output slsc_pkg::slsc_pins_t pins
);
   import slsc_pkg::*;
   logic [2:0] hold_q = 3'h0;
   ////////////////////////////////////////////////////////////
   // sysref stays high a few cycles, then low long enough to space the rises
   always_ff @(posedge ref_clk)
   begin
      hold_q <= fire ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
      pins.sysref <= fire | (hold_q > 3'h1);
      pins.syncb_diff <= diff_lvl;
      pins.aux_pin_four <= aux_lvl;
   end
endmodule // slsc_link_model

// ---- test/slsc_regs_tb_top.sv ----
// self-checking bench for the sync control register bank
`timescale 1ns/10ps
`include "slsc_consts.svh"
module slsc_regs_tb_top;
   import slsc_pkg::*;
   logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, syncb_to_link;
   logic [9:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic [1:0] pll_factor;
   logic [6:0] pll_mult;
   logic diff_lvl, aux_lvl, fire;
   logic [7:0] rd;
   slsc_pins_t link_pins;
   slsc_sync_out_t sysref_resets;
   int mismatches = 0;
   int samples_checked = 0;

   slsc_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link_pins(link_pins),
      .syncb_to_link(syncb_to_link), .pll_factor(pll_factor), .pll_mult(pll_mult),
      .sysref_resets(sysref_resets));
   slsc_link_model far_end (.ref_clk(ref_clk), .diff_lvl(diff_lvl), .aux_lvl(aux_lvl),
      .fire(fire), .pins(link_pins));

   ////////////////////////////////////////////////////////////
   // clock at 125 mhz
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon transfer; request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
         output logic [7:0] q);
      avs_address <= {idx, 2'b00};
      avs_write <= wr;
      avs_read <= ~wr;
      avs_writedata <= {24'h0, wd};
      // no cycle count assumed; a hang is ended by the watchdog
      do
         @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic test_reset();
      logic [7:0] idxs [6] = '{8'h16, 8'h36, 8'h37, 8'h3c, 8'h3e, 8'h20};
      foreach (idxs[i])
      begin
         bus(1'b0, idxs[i], 8'h00, rd);
         check(rd, 8'h00);
      end
      check({1'b0, pll_mult}, {1'b0, `SLSC_MULT_20X});
      check({7'h0, syncb_to_link}, 8'h01);
      $display("test reset done");
   endtask

   // every pll code, with the forty-times field set to match
   task automatic test_pll();
      logic [6:0] mult [4] = '{7'h14, 7'h10, 7'h28, 7'h50};
      for (int i = 0; i < 4; i++)
      begin
         bus(1'b1, `SLSC_IDX_FORTY, (i == 2) ? 8'h70 : 8'h00, rd);
         bus(1'b1, `SLSC_IDX_PLL, 8'(i), rd);
         bus(1'b0, `SLSC_IDX_PLL, 8'h00, rd);
         check(rd, 8'(i));
         check({6'h0, pll_factor}, 8'(i));
         check({1'b0, pll_mult}, {1'b0, mult[i]});
         bus(1'b0, `SLSC_IDX_STATUS, 8'h00, rd);
         check(rd & 8'h08, 8'h00);
      end
      bus(1'b1, `SLSC_IDX_PLL, {6'h0, `SLSC_PLL_40X}, rd);
      bus(1'b0, `SLSC_IDX_STATUS, 8'h00, rd);
      check(rd & 8'h08, 8'h08);
      $display("test pll done");
   endtask

   // source switch needs select, enable and page control together
   task automatic test_sync();
      diff_lvl <= 1'b1;
      aux_lvl <= 1'b0;
      bus(1'b1, `SLSC_IDX_PAGE_CTRL, 8'h01, rd);
      bus(1'b1, `SLSC_IDX_SYNC_SEL, 8'h40, rd);
      repeat (6) @(posedge ref_clk);
      check({7'h0, syncb_to_link}, 8'h01);
      bus(1'b1, `SLSC_IDX_SE_EN, 8'h01, rd);
      repeat (6) @(posedge ref_clk);
      check({7'h0, syncb_to_link}, 8'h00);
      bus(1'b0, `SLSC_IDX_SYNC_SEL, 8'h00, rd);
      check(rd, 8'h40);
      bus(1'b0, `SLSC_IDX_STATUS, 8'h00, rd);
      check(rd & 8'h01, 8'h01);
      diff_lvl <= 1'b0;
      aux_lvl <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check({7'h0, syncb_to_link}, 8'h01);
      bus(1'b1, `SLSC_IDX_PAGE_CTRL, 8'h00, rd);
      repeat (6) @(posedge ref_clk);
      check({7'h0, syncb_to_link}, 8'h00);
      $display("test sync done");
   endtask

   // one sysref rise under each of the four mask settings
   task automatic test_sysref();
      int nd, nn, nl;
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, `SLSC_IDX_SYSREF_MASK, 8'(m << 5), rd);
         bus(1'b0, `SLSC_IDX_SYSREF_MASK, 8'h00, rd);
         check(rd, 8'(m << 5));
         nd = 0;
         nn = 0;
         nl = 0;
         fire <= 1'b1;
         @(posedge ref_clk);
         fire <= 1'b0;
         repeat (14)
         begin
            @(posedge ref_clk);
            nd += sysref_resets.clkdiv_rst;
            nn += sysref_resets.nco_rst;
            nl += sysref_resets.lmfc_rst;
         end
         check(8'(nd), {7'h0, ~m[1]});
         check(8'(nn), {7'h0, ~m[0]});
         check(8'(nl), {7'h0, ~m[0]});
      end
      $display("test sysref done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #100us;
      mismatches++;
      print_verdict();
   end

   // main sequence
   initial
   begin
      sys_rst = 1'b1;
      avs_address = 10'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h1;
      diff_lvl = 1'b1;
      aux_lvl = 1'b1;
      fire = 1'b0;
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      // syncb must stay deasserted through the synchronisers' settling edges
      repeat (4)
      begin
         @(posedge ref_clk);
         check({7'h0, syncb_to_link}, 8'h01);
      end
      test_reset();
      test_pll();
      test_sync();
      test_sysref();
      print_verdict();
   end
endmodule // slsc_regs_tb_top
